// >>> hdl/ebrs_top.v
// Readout counters, byte counter and network block thresholds with a Wishbone slave
`timescale 1ns/1ps

// How it works
// (RULE_01) Keep last trigger number, cleared by soft reset
// (RULE_02) Count readout acknowledges, cleared by soft reset
// (RULE_03) Count sent bytes in 64 bits
// (RULE_04) Low-word read captures high word for later
// (RULE_05) Software reads low word, then high word
// (RULE_06) Size limit sets buffer full and wrap
// (RULE_07) Program size limit before releasing DMA reset
// (RULE_08) Send network block before exceeding size limit
// (RULE_09) Send network block at block-count limit
// (RULE_10) Send network block after idle timeout
// (RULE_11) Idle timeout counts 12.8 ns ticks
// (RULE_12) Restart idle timer on append and start
module ebrs_top (
    input wire SYS_CLK,
    input wire RST_N,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [15:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    input wire TRIG_DONE,
    input wire [31:0] LAST_TRIGGER_NUMBER_IN,
    input wire ACK_SENT,
    input wire TX_BYTES_VALID,
    input wire [15:0] TX_BYTES,
    input wire EVT_BLOCK_VALID,
    input wire [31:0] EVT_BLOCK_WORDS,
    input wire DDR_WR_VALID,
    input wire [31:0] DDR_WR_WORDS,
    input wire DDR_RD_VALID,
    input wire [31:0] DDR_RD_WORDS,
    output reg NET_SEND,
    output reg [31:0] NET_SEND_WORDS,
    output reg [31:0] NET_SEND_BLOCKS,
    output reg [1:0] NET_SEND_CAUSE,
    output reg [31:0] DDR_WR_PTR,
    output reg [31:0] DDR_RD_PTR,
    output reg DDR_FULL,
    output reg SOFT_RESET,
    output reg DMA_RESET
);
`include "ebrs_defs.vh"

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Advance a buffer pointer by len words, wrapping at the size limit.
    function [31:0] wrap_add;
        input [31:0] ptr;
        input [31:0] len;
        input [31:0] lim;
        reg [32:0] sum;
        begin
            sum = {1'b0, ptr} + {1'b0, len};
            if (lim != 32'h0 && sum >= {1'b0, lim}) begin
                sum = sum - {1'b0, lim};
            end
            wrap_add = sum[31:0];
        end
    endfunction

    function [31:0] apply_sel;
        input [31:0] old;
        input [31:0] wdat;
        input [3:0] sel;
        integer i;
        begin
            apply_sel = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    apply_sel[i*8 +: 8] = wdat[i*8 +: 8];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    reg [31:0] ctrl_q;
    reg [31:0] size_limit_q;
    reg [11:0] count_limit_q;
    reg [31:0] idle_timeout_q;
    reg [31:0] last_trigger_number_q;
    reg [31:0] ack_count_q;
    reg [63:0] bytes_q;
    reg [31:0] bytes_high_snap_q;
    reg [31:0] fill_q;
    reg [31:0] rdata;
    reg block_open_q;

    wire bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire bus_wr = bus_req && WB_WE_I;
    wire bus_rd = bus_req && !WB_WE_I;
    wire soft_rst = ctrl_q[`EBRS_CTRL_SOFT_RESET_BIT];
    wire dma_rst = ctrl_q[`EBRS_CTRL_DMA_RESET_BIT];
    wire [31:0] count_limit_wr = apply_sel({20'h0, count_limit_q}, WB_DAT_I, WB_SEL_I);

    // Unmapped addresses read as zero and ignore writes, but still ack.
    always @* begin
        case (WB_ADR_I)
            `EBRS_OFF_CTRL: rdata = ctrl_q;
            `EBRS_OFF_LAST_TRIGGER_NUMBER: rdata = last_trigger_number_q;
            `EBRS_OFF_BYTES_LOW: rdata = bytes_q[31:0];
            `EBRS_OFF_BYTES_HIGH: rdata = bytes_high_snap_q; // RULE_04
            `EBRS_OFF_ACK_COUNT: rdata = ack_count_q;
            `EBRS_OFF_STATUS: rdata = {30'h0, block_open_q, DDR_FULL};
            `EBRS_OFF_SIZE_LIMIT: rdata = size_limit_q;
            `EBRS_OFF_COUNT_LIMIT: rdata = {20'h0, count_limit_q};
            `EBRS_OFF_IDLE_TIMEOUT: rdata = idle_timeout_q;
            default: rdata = 32'h0;
        endcase
    end

    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0;
            ctrl_q <= `EBRS_CTRL_RESET;
            size_limit_q <= `EBRS_SIZE_LIMIT_RESET;
            count_limit_q <= `EBRS_COUNT_LIMIT_RESET;
            idle_timeout_q <= `EBRS_IDLE_TIMEOUT_RESET;
            bytes_high_snap_q <= 32'h0;
        end else begin
            WB_ACK_O <= bus_req;
            if (bus_rd) begin
                WB_DAT_O <= rdata;
            end
            if (bus_wr) begin
                case (WB_ADR_I)
                    `EBRS_OFF_CTRL:
                        ctrl_q <= apply_sel(ctrl_q, WB_DAT_I, WB_SEL_I) & `EBRS_CTRL_MASK;
                    `EBRS_OFF_SIZE_LIMIT:
                        size_limit_q <= apply_sel(size_limit_q, WB_DAT_I, WB_SEL_I);
                    `EBRS_OFF_COUNT_LIMIT: begin
                        count_limit_q <= count_limit_wr[11:0];
                    end
                    `EBRS_OFF_IDLE_TIMEOUT:
                        idle_timeout_q <= apply_sel(idle_timeout_q, WB_DAT_I, WB_SEL_I);
                    default: begin
                    end
                endcase
            end
            // Snapshot taken in the same cycle as the low word is sampled,
            // so the pair is coherent even while bytes keep flowing.
            if (soft_rst) begin
                bytes_high_snap_q <= 32'h0; // RULE_03
            end else if (bus_rd && WB_ADR_I == `EBRS_OFF_BYTES_LOW) begin
                bytes_high_snap_q <= bytes_q[63:32]; // RULE_04 RULE_05
            end
        end
    end

    // ------------------------------------------------------------------
    // Readout counters
    // ------------------------------------------------------------------
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            last_trigger_number_q <= 32'h0;
            ack_count_q <= 32'h0;
            bytes_q <= 64'h0;
            SOFT_RESET <= 1'b0;
            DMA_RESET <= 1'b1;
        end else begin
            SOFT_RESET <= soft_rst;
            DMA_RESET <= dma_rst;
            if (soft_rst) begin
                last_trigger_number_q <= 32'h0; // RULE_01
                ack_count_q <= 32'h0; // RULE_02
                bytes_q <= 64'h0; // RULE_03
            end else begin
                if (TRIG_DONE) begin
                    last_trigger_number_q <= LAST_TRIGGER_NUMBER_IN; // RULE_01
                end
                if (ACK_SENT) begin
                    ack_count_q <= ack_count_q + 32'h1; // RULE_02
                end
                if (TX_BYTES_VALID) begin
                    bytes_q <= bytes_q + {48'h0, TX_BYTES}; // RULE_03
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // External buffer pointers
    // ------------------------------------------------------------------
    // The size limit is only safe to change while the DMA reset is held;
    // changing it live can leave a pointer beyond the new wrap point.
    reg [31:0] fill_d;

    always @* begin
        fill_d = fill_q;
        if (DDR_WR_VALID) begin
            fill_d = fill_d + DDR_WR_WORDS;
        end
        if (DDR_RD_VALID) begin
            fill_d = fill_d - DDR_RD_WORDS;
        end
    end

    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            DDR_WR_PTR <= 32'h0;
            DDR_RD_PTR <= 32'h0;
            fill_q <= 32'h0;
            DDR_FULL <= 1'b0;
        end else if (dma_rst) begin // RULE_07
            DDR_WR_PTR <= 32'h0;
            DDR_RD_PTR <= 32'h0;
            fill_q <= 32'h0;
            DDR_FULL <= 1'b0;
        end else begin
            if (DDR_WR_VALID) begin
                DDR_WR_PTR <= wrap_add(DDR_WR_PTR, DDR_WR_WORDS, size_limit_q); // RULE_06
            end
            if (DDR_RD_VALID) begin
                DDR_RD_PTR <= wrap_add(DDR_RD_PTR, DDR_RD_WORDS, size_limit_q); // RULE_06
            end
            fill_q <= fill_d;
            DDR_FULL <= (size_limit_q != 32'h0) && (fill_d >= size_limit_q); // RULE_06
        end
    end

    // ------------------------------------------------------------------
    // Network block builder
    // ------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_OPEN = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [31:0] words_q;
    reg [31:0] words_d;
    reg [31:0] blocks_q;
    reg [31:0] blocks_d;
    reg send_d;
    reg [31:0] send_words_d;
    reg [31:0] send_blocks_d;
    reg [1:0] send_cause_d;
    reg timer_restart;
    reg [32:0] words_sum;
    wire idle_expired;

    ebrs_idle_timer u_idle_timer (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .run(state_q == ST_OPEN),
        .restart(timer_restart),
        .limit(idle_timeout_q),
        .expired(idle_expired)
    );

    always @* begin
        state_d = state_q;
        words_d = words_q;
        blocks_d = blocks_q;
        send_d = 1'b0;
        send_words_d = 32'h0;
        send_blocks_d = 32'h0;
        send_cause_d = 2'h0;
        timer_restart = 1'b0;
        words_sum = {1'b0, words_q} + {1'b0, EVT_BLOCK_WORDS};
        case (state_q)
            ST_IDLE: begin
                if (EVT_BLOCK_VALID) begin
                    state_d = ST_OPEN;
                    words_d = EVT_BLOCK_WORDS;
                    blocks_d = 32'h1;
                    timer_restart = 1'b1; // RULE_12
                end
            end
            ST_OPEN: begin
                if (EVT_BLOCK_VALID) begin
                    timer_restart = 1'b1; // RULE_12
                    if (size_limit_q != 32'h0 && words_sum > {1'b0, size_limit_q}) begin
                        // Close before the limit is passed; the new block
                        // opens the next network block.
                        send_d = 1'b1; // RULE_08
                        send_words_d = words_q;
                        send_blocks_d = blocks_q;
                        send_cause_d = `EBRS_CAUSE_SIZE;
                        words_d = EVT_BLOCK_WORDS;
                        blocks_d = 32'h1;
                    end else begin
                        words_d = words_sum[31:0];
                        blocks_d = blocks_q + 32'h1;
                    end
                end else if (idle_expired) begin
                    send_d = 1'b1; // RULE_10
                    send_words_d = words_q;
                    send_blocks_d = blocks_q;
                    send_cause_d = `EBRS_CAUSE_IDLE;
                    state_d = ST_IDLE;
                    words_d = 32'h0;
                    blocks_d = 32'h0;
                end
            end
            default: begin
                state_d = ST_IDLE;
                words_d = 32'h0;
                blocks_d = 32'h0;
            end
        endcase
        // Count limit checked after the append; a size-forced send in the
        // same cycle takes priority and the count check waits one cycle.
        if (!send_d && state_d == ST_OPEN && count_limit_q != 12'h0 &&
            blocks_d >= {20'h0, count_limit_q}) begin
            send_d = 1'b1; // RULE_09
            send_words_d = words_d;
            send_blocks_d = blocks_d;
            send_cause_d = `EBRS_CAUSE_COUNT;
            state_d = ST_IDLE;
            words_d = 32'h0;
            blocks_d = 32'h0;
        end
    end

    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            words_q <= 32'h0;
            blocks_q <= 32'h0;
            block_open_q <= 1'b0;
            NET_SEND <= 1'b0;
            NET_SEND_WORDS <= 32'h0;
            NET_SEND_BLOCKS <= 32'h0;
            NET_SEND_CAUSE <= 2'h0;
        end else if (soft_rst) begin
            state_q <= ST_IDLE;
            words_q <= 32'h0;
            blocks_q <= 32'h0;
            block_open_q <= 1'b0;
            NET_SEND <= 1'b0;
            NET_SEND_WORDS <= 32'h0;
            NET_SEND_BLOCKS <= 32'h0;
            NET_SEND_CAUSE <= 2'h0;
        end else begin
            state_q <= state_d;
            words_q <= words_d;
            blocks_q <= blocks_d;
            block_open_q <= (state_d == ST_OPEN);
            NET_SEND <= send_d;
            if (send_d) begin
                NET_SEND_WORDS <= send_words_d;
                NET_SEND_BLOCKS <= send_blocks_d;
                NET_SEND_CAUSE <= send_cause_d;
            end
        end
    end

endmodule // ebrs_top

// >>> hdl/ebrs_defs.vh
// Register map, reset values and timing constants of the readout statistics block
`ifndef EBRS_DEFS_VH
`define EBRS_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define EBRS_OFF_CTRL 16'h0000
`define EBRS_OFF_LAST_TRIGGER_NUMBER 16'h0040
`define EBRS_OFF_BYTES_LOW 16'h0044
`define EBRS_OFF_BYTES_HIGH 16'h0048
`define EBRS_OFF_ACK_COUNT 16'h004c
`define EBRS_OFF_STATUS 16'h0050
`define EBRS_OFF_SIZE_LIMIT 16'h0070
`define EBRS_OFF_COUNT_LIMIT 16'h0074
`define EBRS_OFF_IDLE_TIMEOUT 16'h0078

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define EBRS_CTRL_SOFT_RESET_BIT 0
`define EBRS_CTRL_DMA_RESET_BIT 3
`define EBRS_CTRL_MASK 32'h00000009
`define EBRS_CTRL_RESET 32'h00000008
`define EBRS_COUNT_LIMIT_W 12
`define EBRS_SIZE_LIMIT_RESET 32'h00000000
`define EBRS_COUNT_LIMIT_RESET 12'h000
`define EBRS_IDLE_TIMEOUT_RESET 32'h00000000
`define EBRS_STAT_DDR_FULL_BIT 0
`define EBRS_STAT_BLOCK_OPEN_BIT 1

// ----------------------------------------------------------------------
// Send causes
// ----------------------------------------------------------------------
`define EBRS_CAUSE_SIZE 2'h1
`define EBRS_CAUSE_COUNT 2'h2
`define EBRS_CAUSE_IDLE 2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define EBRS_CLK_PERIOD_PS 50000
`define EBRS_TICK_PS 12800
`define EBRS_TICK_FRAC_BITS 5
`define EBRS_TICK_FRAC 32

`endif

// >>> hdl/ebrs_idle_timer.v
// Idle timeout timer counting in fixed 12.8 ns ticks from the system clock
`timescale 1ns/1ps

module ebrs_idle_timer (
    input wire clk,
    input wire rst_n,
    input wire run,
    input wire restart,
    input wire [31:0] limit,
    output reg expired
);
`include "ebrs_defs.vh"

    // ------------------------------------------------------------------
    // Fractional tick accumulator
    // ------------------------------------------------------------------
    // One clock is not a whole number of ticks, so time is kept in
    // 1/32 tick units; 50 ns is exactly 125 of them, so nothing drifts.
    localparam [37:0] STEP = (`EBRS_CLK_PERIOD_PS * `EBRS_TICK_FRAC) / `EBRS_TICK_PS;

    reg [37:0] elapsed_q;
    reg [37:0] elapsed_d;
    reg expired_d;
    wire [37:0] limit_frac;

    assign limit_frac = {1'b0, limit, {`EBRS_TICK_FRAC_BITS{1'b0}}};

    always @* begin
        elapsed_d = elapsed_q;
        expired_d = 1'b0;
        if (!run || restart) begin // RULE_12
            elapsed_d = 38'h0;
        end else if (limit != 32'h0) begin
            if (elapsed_q >= limit_frac) begin // RULE_11
                expired_d = 1'b1;
            end else begin
                elapsed_d = elapsed_q + STEP;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            elapsed_q <= 38'h0;
            expired <= 1'b0;
        end else begin
            elapsed_q <= elapsed_d;
            expired <= expired_d;
        end
    end

endmodule // ebrs_idle_timer

// >>> sim/ebrs_checker.sv
// Port-level assertions for the readout statistics block
`timescale 1ns/1ps

module ebrs_checker (
    input wire SYS_CLK,
    input wire RST_N,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [15:0] WB_ADR_I,
    input wire [31:0] WB_DAT_O,
    input wire WB_ACK_O,
    input wire EVT_BLOCK_VALID,
    input wire NET_SEND,
    input wire [1:0] NET_SEND_CAUSE,
    input wire [31:0] DDR_WR_PTR,
    input wire [31:0] DDR_RD_PTR,
    input wire DDR_FULL,
    input wire SOFT_RESET,
    input wire DMA_RESET
);
    // ----------
    // Assertions
    // ----------
    wire rd = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I;
    wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    // Soft reset seen for two cycles, so the cleared counters have landed
    wire clr = SOFT_RESET && rd;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    AST_ACK_ONE: assert property (req |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("bus answer is not a single pulse one cycle after the request");
    AST_RD_HOLD: assert property (!$past(rd) |-> $stable(WB_DAT_O))
        else $error("read data moved without a read");
    AST_TRIG_CLR: assert property (clr && $past(SOFT_RESET) && WB_ADR_I == 16'h0040
        |=> WB_DAT_O == 32'h00000000) else $error("trigger number not cleared");
    AST_ACKS_CLR: assert property (clr && $past(SOFT_RESET) && WB_ADR_I == 16'h004c
        |=> WB_DAT_O == 32'h00000000) else $error("acknowledge count not cleared");
    AST_BYTES_CLR: assert property (clr && $past(SOFT_RESET) && WB_ADR_I == 16'h0044
        |=> WB_DAT_O == 32'h00000000) else $error("byte count not cleared");
    AST_DMA_HOLD: assert property (DMA_RESET && $past(DMA_RESET)
        |-> DDR_WR_PTR == 32'h0 && DDR_RD_PTR == 32'h0 && !DDR_FULL)
        else $error("buffer pointers move while the DMA reset is held");
    AST_SIZE_CAUSE: assert property (NET_SEND && NET_SEND_CAUSE == 2'h1
        |-> $past(EVT_BLOCK_VALID)) else $error("size send without an append");
    AST_COUNT_CAUSE: assert property (NET_SEND && NET_SEND_CAUSE == 2'h2
        |-> $past(EVT_BLOCK_VALID) || $past(EVT_BLOCK_VALID, 2))
        else $error("count send without a recent append");
    AST_IDLE_CAUSE: assert property (NET_SEND && NET_SEND_CAUSE == 2'h3
        |-> !$past(EVT_BLOCK_VALID) && !$past(EVT_BLOCK_VALID, 2))
        else $error("idle send right after an append");
    AST_SEND_QUIET: assert property (SOFT_RESET && $past(SOFT_RESET) |-> !NET_SEND)
        else $error("send during soft reset");
    AST_SEND_CAUSE: assert property (NET_SEND |-> NET_SEND_CAUSE != 2'h0)
        else $error("send with no cause");
endmodule // ebrs_checker

bind ebrs_top ebrs_checker chk_u (.SYS_CLK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
    .WB_ADR_I, .WB_DAT_O, .WB_ACK_O, .EVT_BLOCK_VALID, .NET_SEND, .NET_SEND_CAUSE,
    .DDR_WR_PTR, .DDR_RD_PTR, .DDR_FULL, .SOFT_RESET, .DMA_RESET);

// >>> sim/ebrs_far_side.sv
// Far-side model: trigger board, network stack and memory DMA strobes
`timescale 1ns/1ps

module ebrs_far_side (
    input wire clk,
    output wire trig_done,
    output wire [31:0] last_trigger_number,
    output wire ack_sent,
    output wire tx_valid,
    output wire [15:0] tx_bytes,
    output wire evt_valid,
    output wire [31:0] evt_words,
    output wire wr_valid,
    output wire [31:0] wr_words,
    output wire rd_valid,
    output wire [31:0] rd_words
);
    // ----------
    // Strobes
    // ----------
    reg [5:0] v_q = 6'h00;
    reg [31:0] d_q [0:5];
    integer i;

    initial begin
        for (i = 0; i < 6; i = i + 1) begin
            d_q[i] = 32'h5a5a5a5a;
        end
    end

    assign trig_done = v_q[0];
    assign last_trigger_number = d_q[0];
    assign ack_sent = v_q[1];
    assign tx_valid = v_q[2];
    assign tx_bytes = d_q[2][15:0];
    assign evt_valid = v_q[3];
    assign evt_words = d_q[3];
    assign wr_valid = v_q[4];
    assign wr_words = d_q[4];
    assign rd_valid = v_q[5];
    assign rd_words = d_q[5];

    // Keep leaves the strobe up so the next call lands back to back
    task fire(input integer k, input [31:0] x, input bit keep);
        @(posedge clk);
        v_q[k] <= 1'b1;
        d_q[k] <= x;
        if (!keep) begin
            @(posedge clk);
            v_q[k] <= 1'b0;
            // Stale data is inverted so a missed strobe check cannot pass by luck
            d_q[k] <= ~x;
        end
    endtask
endmodule // ebrs_far_side

// >>> sim/tb_ebrs_top.sv
// Self-checking bench for the readout statistics block
`timescale 1ns/1ps

module tb_ebrs_top;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg cyc = 1'b0;
    reg stb = 1'b0;
    reg we = 1'b0;
    reg [15:0] adr = 16'h0000;
    reg [31:0] wdat = 32'h00000000;
    wire [31:0] rdat, trig_no, evt_words, wr_words, rd_words, snd_words, snd_blocks;
    wire [31:0] wr_ptr, rd_ptr;
    wire [15:0] tx_bytes;
    wire [1:0] snd_cause;
    wire ack, trig_done, ack_sent, tx_valid, evt_valid, wr_valid, rd_valid;
    wire snd, ddr_full, soft_rst, dma_rst;
    integer error_cnt = 0;
    integer total_checks = 0;
    integer i;
    integer gap;
    reg [31:0] rv;
    reg [80:0] rows [0:21];

    always #25 clk = ~clk;

    ebrs_top dut_u (.SYS_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .TRIG_DONE(trig_done), .LAST_TRIGGER_NUMBER_IN(trig_no), .ACK_SENT(ack_sent),
        .TX_BYTES_VALID(tx_valid), .TX_BYTES(tx_bytes), .EVT_BLOCK_VALID(evt_valid),
        .EVT_BLOCK_WORDS(evt_words), .DDR_WR_VALID(wr_valid), .DDR_WR_WORDS(wr_words),
        .DDR_RD_VALID(rd_valid), .DDR_RD_WORDS(rd_words), .NET_SEND(snd),
        .NET_SEND_WORDS(snd_words), .NET_SEND_BLOCKS(snd_blocks), .NET_SEND_CAUSE(snd_cause),
        .DDR_WR_PTR(wr_ptr), .DDR_RD_PTR(rd_ptr), .DDR_FULL(ddr_full),
        .SOFT_RESET(soft_rst), .DMA_RESET(dma_rst));

    ebrs_far_side far_u (.clk(clk), .trig_done(trig_done), .last_trigger_number(trig_no),
        .ack_sent(ack_sent), .tx_valid(tx_valid), .tx_bytes(tx_bytes), .evt_valid(evt_valid),
        .evt_words(evt_words), .wr_valid(wr_valid), .wr_words(wr_words),
        .rd_valid(rd_valid), .rd_words(rd_words));

    // ----------
    // Tasks
    // ----------
    task finish_test;
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task chk(input string nm, input [31:0] seen, input [31:0] exp_v);
        total_checks = total_checks + 1;
        if (seen !== exp_v) begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp_v, seen);
        end
    endtask

    task wb(input bit w, input [15:0] a, input [31:0] d, output [31:0] r);
        integer n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n = n + 1;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            error_cnt = error_cnt + 1;
            finish_test();
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task wait_send(input [31:0] w, input [31:0] b, input [1:0] c);
        gap = 0;
        do begin
            @(posedge clk);
            gap = gap + 1;
        end while (snd !== 1'b1 && gap < 60);
        if (snd !== 1'b1) begin
            error_cnt = error_cnt + 1;
            finish_test();
        end
        chk("send_words", snd_words, w);
        chk("send_blocks", snd_blocks, b);
        chk("send_cause", {30'h0, snd_cause}, {30'h0, c});
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt = error_cnt + 1;
        finish_test();
    end

    // ----------
    // Sequence
    // ----------
    initial begin
        // Row: write flag, address, write data, expected read data
        rows = '{{1'h0, 16'h0000, 32'h0, 32'h00000008}, {1'h0, 16'h0040, 32'h0, 32'h0},
            {1'h0, 16'h0044, 32'h0, 32'h0}, {1'h0, 16'h0048, 32'h0, 32'h0},
            {1'h0, 16'h004c, 32'h0, 32'h0}, {1'h0, 16'h0050, 32'h0, 32'h0},
            {1'h0, 16'h0070, 32'h0, 32'h0}, {1'h0, 16'h0074, 32'h0, 32'h0},
            {1'h0, 16'h0078, 32'h0, 32'h0}, {1'h1, 16'h004c, 32'h12345678, 32'h0},
            {1'h0, 16'h004c, 32'h0, 32'h0}, {1'h1, 16'h0070, 32'hffffffff, 32'h0},
            {1'h0, 16'h0070, 32'h0, 32'hffffffff}, {1'h1, 16'h0074, 32'hffffffff, 32'h0},
            {1'h0, 16'h0074, 32'h0, 32'h00000fff}, {1'h1, 16'h0078, 32'ha5a5a5a5, 32'h0},
            {1'h0, 16'h0078, 32'h0, 32'ha5a5a5a5}, {1'h1, 16'h003c, 32'h11111111, 32'h0},
            {1'h0, 16'h003c, 32'h0, 32'h0}, {1'h1, 16'h0070, 32'h0, 32'h0},
            {1'h1, 16'h0074, 32'h0, 32'h0}, {1'h1, 16'h0078, 32'h0, 32'h0}};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 22; i = i + 1) begin
            wb(rows[i][80], rows[i][79:64], rows[i][63:32], rv);
            if (!rows[i][80]) chk("reg_table", rv, rows[i][31:0]);
        end
        far_u.fire(0, 32'h1234abcd, 0);
        far_u.fire(1, 32'h0, 1);
        far_u.fire(1, 32'h0, 0);
        far_u.fire(1, 32'h0, 0);
        far_u.fire(2, 32'h00000064, 1);
        far_u.fire(2, 32'h0000ffff, 0);
        wb(0, 16'h0040, 32'h0, rv);
        chk("last_trigger_number", rv, 32'h1234abcd);
        wb(0, 16'h004c, 32'h0, rv);
        chk("ack_count", rv, 32'h00000003);
        // Low word first, high word straight after, for a coherent pair
        wb(0, 16'h0044, 32'h0, rv);
        chk("bytes_low", rv, 32'h00010063);
        wb(0, 16'h0048, 32'h0, rv);
        chk("bytes_high", rv, 32'h00000000);
        // Soft reset held: counters clear and strobes are ignored
        wb(1, 16'h0000, 32'h00000009, rv);
        far_u.fire(0, 32'h55aa55aa, 0);
        far_u.fire(1, 32'h0, 0);
        far_u.fire(2, 32'h00000010, 0);
        chk("soft_pin", {31'h0, soft_rst}, 32'h1);
        wb(0, 16'h0040, 32'h0, rv);
        chk("trig_cleared", rv, 32'h0);
        wb(0, 16'h004c, 32'h0, rv);
        chk("acks_cleared", rv, 32'h0);
        wb(0, 16'h0044, 32'h0, rv);
        chk("bytes_cleared", rv, 32'h0);
        // Size limit goes in before the DMA reset is let go
        wb(1, 16'h0070, 32'h00000008, rv);
        wb(1, 16'h0000, 32'h00000000, rv);
        far_u.fire(4, 32'h00000005, 1);
        far_u.fire(4, 32'h00000003, 0);
        repeat (2) @(posedge clk);
        chk("wr_ptr_wrap", wr_ptr, 32'h0);
        chk("ddr_full", {31'h0, ddr_full}, 32'h1);
        chk("dma_pin", {31'h0, dma_rst}, 32'h0);
        wb(0, 16'h0050, 32'h0, rv);
        chk("status_full", rv, 32'h00000001);
        far_u.fire(5, 32'h00000004, 0);
        repeat (2) @(posedge clk);
        chk("rd_ptr", rd_ptr, 32'h00000004);
        chk("ddr_not_full", {31'h0, ddr_full}, 32'h0);
        // Exactly at the limit stays open; one more word closes it
        far_u.fire(3, 32'h00000005, 0);
        far_u.fire(3, 32'h00000003, 0);
        far_u.fire(3, 32'h00000001, 0);
        wait_send(32'h8, 32'h2, 2'h1);
        wb(1, 16'h0070, 32'h0, rv);
        wb(1, 16'h0074, 32'h00000002, rv);
        far_u.fire(3, 32'h00000002, 0);
        wait_send(32'h3, 32'h2, 2'h2);
        far_u.fire(3, 32'h00000005, 1);
        far_u.fire(3, 32'h00000003, 0);
        wait_send(32'h8, 32'h2, 2'h2);
        // Appends spaced under the timeout must keep restarting it
        wb(1, 16'h0074, 32'h0, rv);
        wb(1, 16'h0078, 32'h00000028, rv);
        for (i = 0; i < 3; i = i + 1) begin
            if (i > 0) repeat (6) @(posedge clk);
            far_u.fire(3, 32'h00000001, 0);
        end
        wait_send(32'h3, 32'h3, 2'h3);
        chk("idle_gap", {31'h0, gap >= 11 && gap <= 16}, 32'h1);
        // Second reset in mid-run returns registers to their reset values
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wb(0, 16'h0078, 32'h0, rv);
        chk("timeout_reset", rv, 32'h0);
        wb(0, 16'h0000, 32'h0, rv);
        chk("ctrl_reset", rv, 32'h00000008);
        finish_test();
    end
endmodule // tb_ebrs_top
